/* logic/swe_spi_fram_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - The latch-set command sets the write-enable latch, and the latch shows in the status byte.
// - A status write clears the latch flag; so do the latch-clear command and a lower-half write, and latch-set sets it.
// - Completing a lower-half memory write or a status write clears the latch, so later writes are refused until it is set.
// - The latch flag sits at status bit 1, reads 1 when writes are allowed, and is 0 after power-up.
// - Status bits 0 and 4 to 7 ignore writes and always read as zero.
// - Two protect-select bits are held at status bits 2 and 3.
// - The ninth address bit comes from opcode bit 3 and the low eight bits from the address byte.
// - Opcode 0x02 writes the lower half of the array and 0x0A the upper half.
// - Opcode 0x03 reads from the lower half and 0x0B from the upper half.
// - An upper-half write with 0x0A leaves the latch set, so a following write is accepted.
// - The latch-clear command clears the latch, refusing all writes until it is set again.
module swe_spi_fram_ctl
  import swe_pkg::*;
#(
  parameter logic [7:0] LATCH_SET_OP = SWE_OP_LATCH_SET,
  parameter logic [7:0] LATCH_CLR_OP = SWE_OP_LATCH_CLR,
  parameter logic [7:0] STS_READ_OP = SWE_OP_STS_READ,
  parameter logic [7:0] STS_WRITE_OP = SWE_OP_STS_WRITE
) (
  // System clock and power-up reset.
  input wire logic clk,
  input wire logic rst_n,
  // SPI link, mode 0.
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Latch and protect state.
  output logic write_enable_latch,
  output logic protect_sel_lo,
  output logic protect_sel_hi
);

  if (swe_is_mem(LATCH_SET_OP) || swe_is_mem(LATCH_CLR_OP) || swe_is_mem(STS_READ_OP) ||
      swe_is_mem(STS_WRITE_OP)) begin : g_chk
    $error("swe_spi_fram_ctl: command opcode collides with a memory opcode");
  end

  // Link domain, clocked by the serial clock.
  swe_state_e state_r;
  swe_state_e state_nxt;
  logic [2:0] cnt_r;
  logic [6:0] shift_r;
  logic [7:0] byte_nxt;
  logic byte_done;
  logic rd_op_r;
  logic hi_wr_op_r;
  logic [SWE_ADDR_W-1:0] addr_r;
  logic [SWE_ADDR_W-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic latch_s1;
  logic latch_s2;
  logic [1:0] prot_s1;
  logic [1:0] prot_s2;
  logic frame_tgl_r;
  logic set_f_r;
  logic clr_f_r;
  logic lo_wr_f_r;
  logic hi_wr_f_r;
  logic sw_f_r;
  logic [1:0] sw_prot_r;
  logic load;
  logic [7:0] out_src;
  logic so_r;
  logic [6:0] rest_r;
  logic oe_r;

  // System domain.
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic tgl_s1;
  logic tgl_s2;
  logic seen_r;
  logic frame_end;
  logic latch_r;
  logic [1:0] prot_r;

  assign byte_nxt = {shift_r, spi_mosi};
  assign byte_done = (cnt_r == 3'd7);

  always_comb begin
    state_nxt = state_r;
    if (byte_done) begin
      case (state_r)
        SWE_ST_CMD: begin
          if (swe_is_mem(byte_nxt)) begin
            state_nxt = SWE_ST_ADDR;
          end else if (byte_nxt == STS_READ_OP) begin
            state_nxt = SWE_ST_SRD;
          end else if (byte_nxt == STS_WRITE_OP) begin
            state_nxt = SWE_ST_SWR;
          end else begin
            state_nxt = SWE_ST_SKIP;
          end
        end
        SWE_ST_ADDR: state_nxt = rd_op_r ? SWE_ST_RDATA : SWE_ST_WDATA;
        SWE_ST_SWR: state_nxt = SWE_ST_SKIP;
        default: state_nxt = state_r;
      endcase
    end
  end

  // Bit framing; chip select high holds the framer at the command byte.
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      cnt_r <= 3'd0;
      shift_r <= 7'h00;
      state_r <= SWE_ST_CMD;
    end else begin
      cnt_r <= cnt_r + 3'd1;
      shift_r <= byte_nxt[6:0];
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge spi_sck or negedge rst_n) begin
    if (!rst_n) begin
      rd_op_r <= 1'b0;
      hi_wr_op_r <= 1'b0;
      addr_r <= '0;
    end else if (byte_done) begin
      if (state_r == SWE_ST_CMD) begin
        rd_op_r <= swe_is_read(byte_nxt);
        hi_wr_op_r <= (byte_nxt == SWE_OP_WR_HI);
        addr_r <= {byte_nxt[SWE_OP_FOLD_BIT], 8'h00};
      end else if (state_r == SWE_ST_ADDR) begin
        addr_r <= {addr_r[SWE_ADDR_W-1], byte_nxt};
      end else if (state_r == SWE_ST_WDATA || state_r == SWE_ST_RDATA) begin
        addr_r <= addr_r + 9'd1;
      end
    end
  end

  // The first read byte is fetched on the edge that completes the address.
  assign mem_raddr = (state_r == SWE_ST_ADDR) ? {addr_r[SWE_ADDR_W-1], byte_nxt} : addr_r + 9'd1;
  assign mem_we = (state_r == SWE_ST_WDATA) && byte_done && latch_s2;

  swe_mem #(
    .DATA_W(SWE_DATA_W),
    .ADDR_W(SWE_ADDR_W),
    .DEPTH(SWE_MEM_DEPTH)
  ) u_mem (
    .clk(spi_sck),
    .we(mem_we),
    .waddr(addr_r),
    .wdata(byte_nxt),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Latch and protect state brought into the link domain.
  always_ff @(posedge spi_sck or negedge rst_n) begin
    if (!rst_n) begin
      latch_s1 <= SWE_LATCH_RESET;
      latch_s2 <= SWE_LATCH_RESET;
      prot_s1 <= SWE_PROT_RESET;
      prot_s2 <= SWE_PROT_RESET;
    end else begin
      latch_s1 <= latch_r;
      latch_s2 <= latch_s1;
      prot_s1 <= prot_r;
      prot_s2 <= prot_s1;
    end
  end

  // Frame results stay still after the last edge and are taken by the system domain at chip select rise.
  always_ff @(posedge spi_sck or negedge rst_n) begin
    if (!rst_n) begin
      frame_tgl_r <= 1'b0;
      set_f_r <= 1'b0;
      clr_f_r <= 1'b0;
      lo_wr_f_r <= 1'b0;
      hi_wr_f_r <= 1'b0;
      sw_f_r <= 1'b0;
      sw_prot_r <= SWE_PROT_RESET;
    end else if (state_r == SWE_ST_CMD && cnt_r == 3'd0) begin
      frame_tgl_r <= ~frame_tgl_r;
      set_f_r <= 1'b0;
      clr_f_r <= 1'b0;
      lo_wr_f_r <= 1'b0;
      hi_wr_f_r <= 1'b0;
      sw_f_r <= 1'b0;
    end else if (byte_done) begin
      if (state_r == SWE_ST_CMD && byte_nxt == LATCH_SET_OP) begin
        set_f_r <= 1'b1;
      end
      if (state_r == SWE_ST_CMD && byte_nxt == LATCH_CLR_OP) begin
        clr_f_r <= 1'b1;
      end
      if (mem_we && hi_wr_op_r) begin
        hi_wr_f_r <= 1'b1;
      end
      if (mem_we && !hi_wr_op_r) begin
        lo_wr_f_r <= 1'b1;
      end
      if (state_r == SWE_ST_SWR && latch_s2) begin
        sw_f_r <= 1'b1;
        sw_prot_r <= {byte_nxt[SWE_STS_PROT_HI_BIT], byte_nxt[SWE_STS_PROT_LO_BIT]};
      end
    end
  end

  // Output shifter, changing on the falling edge.
  assign load = (cnt_r == 3'd0) && (state_r == SWE_ST_RDATA || state_r == SWE_ST_SRD);
  assign out_src = (state_r == SWE_ST_SRD) ? swe_status(latch_s2, prot_s2) : mem_rdata;

  always_ff @(negedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      so_r <= 1'b0;
      rest_r <= 7'h00;
      oe_r <= 1'b0;
    end else if (load) begin
      so_r <= out_src[7];
      rest_r <= out_src[6:0];
      oe_r <= 1'b1;
    end else begin
      so_r <= rest_r[6];
      rest_r <= {rest_r[5:0], 1'b0};
    end
  end

  // System domain: chip select and frame toggle synchronisers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      tgl_s1 <= frame_tgl_r;
      tgl_s2 <= tgl_s1;
      if (frame_end) begin
        seen_r <= tgl_s2;
      end
    end
  end

  // A chip select pulse with no clock edges carries no command.
  assign frame_end = cs_s2 && !cs_s3 && (tgl_s2 != seen_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= SWE_LATCH_RESET;
    end else if (frame_end) begin
      if (clr_f_r) begin
        latch_r <= 1'b0;
      end else if (set_f_r) begin
        latch_r <= 1'b1;
      end else if (lo_wr_f_r || sw_f_r) begin
        latch_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_r <= SWE_PROT_RESET;
    end else if (frame_end && sw_f_r) begin
      prot_r <= sw_prot_r;
    end
  end

  assign spi_miso = so_r;
  assign spi_miso_oe = oe_r;
  assign write_enable_latch = latch_r;
  assign protect_sel_lo = prot_r[0];
  assign protect_sel_hi = prot_r[1];

  latch_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    frame_end && set_f_r && !clr_f_r |=> latch_r)
    else $error("latch not set by latch-set command");

  sw_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    frame_end && sw_f_r && !set_f_r && !clr_f_r |=> !latch_r && prot_r == $past(sw_prot_r))
    else $error("status write handled wrongly");

  wr_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    frame_end && lo_wr_f_r && !set_f_r && !clr_f_r |=> !latch_r ##1 !latch_r)
    else $error("latch not cleared after lower write");

  latch_reset_a: assert property (@(posedge clk) !rst_n |-> !latch_r && prot_r == 2'h0)
    else $error("latch or protect not zero in reset");

  sts_bits_a: assert property (@(posedge spi_sck) disable iff (!rst_n || spi_cs_n)
    state_r == SWE_ST_SRD |-> out_src[7:4] == 4'h0 && !out_src[0] && out_src[1] == latch_s2)
    else $error("status byte layout wrong");

  prot_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(frame_end && sw_f_r) |=> $stable(prot_r))
    else $error("protect bits changed without status write");

  fold_bit_a: assert property (@(posedge spi_sck) disable iff (!rst_n || spi_cs_n)
    state_r == SWE_ST_CMD && byte_done && swe_is_mem(byte_nxt) |=>
      addr_r[8] == $past(byte_nxt[3]) && state_r == SWE_ST_ADDR)
    else $error("ninth address bit not taken from opcode");

  wr_decode_a: assert property (@(posedge spi_sck) disable iff (!rst_n || spi_cs_n)
    state_r == SWE_ST_CMD && byte_done && (byte_nxt == 8'h02 || byte_nxt == 8'h0A) |=>
      !rd_op_r ##8 state_r == SWE_ST_WDATA)
    else $error("write opcode not decoded");

  rd_decode_a: assert property (@(posedge spi_sck) disable iff (!rst_n || spi_cs_n)
    state_r == SWE_ST_CMD && byte_done && (byte_nxt == 8'h03 || byte_nxt == 8'h0B) |=>
      rd_op_r ##8 state_r == SWE_ST_RDATA)
    else $error("read opcode not decoded");

  hi_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    frame_end && hi_wr_f_r && !lo_wr_f_r && !sw_f_r && !clr_f_r |=> latch_r)
    else $error("latch cleared after upper write");

  latch_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    frame_end && clr_f_r |=> !latch_r)
    else $error("latch not cleared by latch-clear command");

  bit_count_a: assert property (@(posedge spi_sck) disable iff (!rst_n || spi_cs_n)
    cnt_r != 3'd7 |=> cnt_r == $past(cnt_r) + 3'd1)
    else $error("bit counter skipped");

  hi_write_c: cover property (@(posedge clk) disable iff (!rst_n) frame_end && hi_wr_f_r);
  lo_write_c: cover property (@(posedge clk) disable iff (!rst_n) frame_end && lo_wr_f_r);
  sts_read_c: cover property (@(negedge spi_sck) disable iff (!rst_n || spi_cs_n)
    load && state_r == SWE_ST_SRD);
  mem_read_c: cover property (@(negedge spi_sck) disable iff (!rst_n || spi_cs_n)
    load && state_r == SWE_ST_RDATA);

endmodule
`default_nettype wire

/* logic/swe_pkg.sv */
`default_nettype none
package swe_pkg;

  localparam int SWE_DATA_W = 8;
  localparam int SWE_ADDR_W = 9;
  localparam int SWE_MEM_DEPTH = 512;

  // Memory commands; the ninth address bit is folded into the opcode.
  localparam logic [7:0] SWE_OP_WR_LO = 8'h02;
  localparam logic [7:0] SWE_OP_WR_HI = 8'h0A;
  localparam logic [7:0] SWE_OP_RD_LO = 8'h03;
  localparam logic [7:0] SWE_OP_RD_HI = 8'h0B;
  localparam int SWE_OP_FOLD_BIT = 3;

  // Default codes for the latch and status commands.
  localparam logic [7:0] SWE_OP_LATCH_SET = 8'h06;
  localparam logic [7:0] SWE_OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] SWE_OP_STS_READ = 8'h05;
  localparam logic [7:0] SWE_OP_STS_WRITE = 8'h01;

  // Status byte layout and power-up values.
  localparam int SWE_STS_LATCH_BIT = 1;
  localparam int SWE_STS_PROT_LO_BIT = 2;
  localparam int SWE_STS_PROT_HI_BIT = 3;
  localparam logic SWE_LATCH_RESET = 1'b0;
  localparam logic [1:0] SWE_PROT_RESET = 2'h0;

  typedef enum logic [6:0] {
    SWE_ST_CMD = 7'b000_0001,
    SWE_ST_ADDR = 7'b000_0010,
    SWE_ST_WDATA = 7'b000_0100,
    SWE_ST_RDATA = 7'b000_1000,
    SWE_ST_SRD = 7'b001_0000,
    SWE_ST_SWR = 7'b010_0000,
    SWE_ST_SKIP = 7'b100_0000
  } swe_state_e;

  function automatic logic swe_is_read(input logic [7:0] op);
    return (op == SWE_OP_RD_LO) || (op == SWE_OP_RD_HI);
  endfunction

  function automatic logic swe_is_mem(input logic [7:0] op);
    return swe_is_read(op) || (op == SWE_OP_WR_LO) || (op == SWE_OP_WR_HI);
  endfunction

  // Unused status bits always read as zero.
  function automatic logic [7:0] swe_status(input logic latch, input logic [1:0] prot);
    logic [7:0] s;
    s = 8'h00;
    s[SWE_STS_LATCH_BIT] = latch;
    s[SWE_STS_PROT_LO_BIT] = prot[0];
    s[SWE_STS_PROT_HI_BIT] = prot[1];
    return s;
  endfunction

endpackage
`default_nettype wire

/* logic/swe_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module swe_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 9,
  parameter int DEPTH = 512
) (
  // Clock.
  input wire logic clk,
  // Write port.
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  // Read port.
  input wire logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);

  if (DEPTH != (1 << ADDR_W)) begin : g_chk
    $error("swe_mem: DEPTH must equal 2**ADDR_W");
  end

  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

/* verification/swe_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module swe_host_model (
  // SPI link, mode 0.
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];

  // The serial clock rests low between frames and only runs inside them.
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // Shifts out tx_q as one frame, msb first, at a 15 ns bit period, and gathers what comes back.
  task automatic run_frame();
    logic [7:0] r;
    rx_q.delete();
    r = 8'h00;
    #3 spi_cs_n = 1'b0;
    foreach (tx_q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        #4 spi_mosi = tx_q[i][b];
        #3.5 r[b] = spi_miso;
        spi_sck = 1'b1;
        #7.5 spi_sck = 1'b0;
      end
      rx_q.push_back(r);
    end
    #10 spi_cs_n = 1'b1;
    // Released data line shows the inverse of its last level so stale values are never read as good.
    spi_mosi = ~spi_mosi;
    tx_q.delete();
  endtask
endmodule
`default_nettype wire

/* verification/swe_spi_fram_ctl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module swe_spi_fram_ctl_test;
  import swe_pkg::*;
  logic clk, rst_n, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic write_enable_latch, protect_sel_lo, protect_sel_hi;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic oe_high_seen;

  // Records whether the device drove its data line at any rising serial clock edge of the current frame.
  always @(posedge spi_sck) begin
    if (spi_miso_oe === 1'b1) begin
      oe_high_seen = 1'b1;
    end
  end

  swe_spi_fram_ctl i_dut (
    .clk(clk), .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .write_enable_latch(write_enable_latch),
    .protect_sel_lo(protect_sel_lo), .protect_sel_hi(protect_sel_hi)
  );

  swe_host_model i_host (
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One frame of n bytes, then enough system cycles for the frame-end effects to land.
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
    logic [7:0] b[3];
    b = '{b0, b1, b2};
    @(posedge clk);
    #2;
    oe_high_seen = 1'b0;
    for (int i = 0; i < n; i++) begin
      i_host.tx_q.push_back(b[i]);
    end
    i_host.run_frame();
    repeat (5) @(posedge clk);
  endtask

  task automatic status_is(input logic [7:0] exp);
    frame(SWE_OP_STS_READ, 8'h00, 8'h00, 2);
    check(i_host.rx_q[1], exp, "status byte");
    check({4'h0, protect_sel_hi, protect_sel_lo, write_enable_latch, 1'b0}, exp, "state pins");
    check({7'h00, oe_high_seen}, 8'h01, "output enable during status byte");
    check({7'h00, spi_miso_oe}, 8'h00, "output enable after frame");
  endtask

  task automatic mem_is(input logic [7:0] op, input logic [7:0] addr, input logic [7:0] exp);
    frame(op, addr, 8'h00, 3);
    check(i_host.rx_q[2], exp, "read byte");
    check({7'h00, oe_high_seen}, 8'h01, "output enable during read byte");
  endtask

  task automatic t_power_up();
    status_is(8'h00);
  endtask

  task automatic t_latch_set();
    frame(SWE_OP_LATCH_SET, 8'h00, 8'h00, 1);
    status_is(8'h02);
  endtask

  task automatic t_lower_write();
    frame(SWE_OP_WR_LO, 8'hA5, 8'h3C, 3);
    status_is(8'h00);
    mem_is(SWE_OP_RD_LO, 8'hA5, 8'h3C);
    frame(SWE_OP_WR_LO, 8'hA5, 8'hFF, 3);
    mem_is(SWE_OP_RD_LO, 8'hA5, 8'h3C);
  endtask

  task automatic t_upper_write();
    frame(SWE_OP_LATCH_SET, 8'h00, 8'h00, 1);
    frame(SWE_OP_WR_HI, 8'hA5, 8'hC3, 3);
    status_is(8'h02);
    mem_is(SWE_OP_RD_HI, 8'hA5, 8'hC3);
    mem_is(SWE_OP_RD_LO, 8'hA5, 8'h3C);
    frame(SWE_OP_WR_LO, 8'h5A, 8'h96, 3);
    mem_is(SWE_OP_RD_LO, 8'h5A, 8'h96);
    status_is(8'h00);
  endtask

  task automatic t_clear_after_upper();
    frame(SWE_OP_LATCH_SET, 8'h00, 8'h00, 1);
    frame(SWE_OP_WR_HI, 8'h10, 8'h44, 3);
    frame(SWE_OP_LATCH_CLR, 8'h00, 8'h00, 1);
    status_is(8'h00);
    frame(SWE_OP_WR_HI, 8'h10, 8'h55, 3);
    mem_is(SWE_OP_RD_HI, 8'h10, 8'h44);
  endtask

  task automatic t_status_write();
    frame(SWE_OP_STS_WRITE, 8'hFF, 8'h00, 2);
    status_is(8'h00);
    frame(SWE_OP_LATCH_SET, 8'h00, 8'h00, 1);
    frame(SWE_OP_STS_WRITE, 8'hFF, 8'h00, 2);
    status_is(8'h0C);
    frame(SWE_OP_LATCH_SET, 8'h00, 8'h00, 1);
    frame(SWE_OP_STS_WRITE, 8'h04, 8'h00, 2);
    status_is(8'h04);
    frame(SWE_OP_LATCH_SET, 8'h00, 8'h00, 1);
    frame(SWE_OP_WR_HI, 8'h20, 8'h11, 3);
    frame(SWE_OP_STS_WRITE, 8'h08, 8'h00, 2);
    status_is(8'h08);
  endtask

  initial begin
    #200_000;
    n_mismatch++;
    $display("unexpected at %0t: run did not complete in time", $time);
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_power_up();
    t_latch_set();
    t_lower_write();
    t_upper_write();
    t_clear_after_upper();
    t_status_write();
    tally_and_finish();
  end
endmodule
`default_nettype wire
